// ### design/fsf_formatter.sv
// Summary of operation
// - response code 70h/71h by type, fixed format only
// - deferred when error belongs to earlier command
// - byte 0 bits 6..0 hold 70h or 71h
// - byte 0 bit 7 is the valid flag
// - byte 2 bit 5 mismatch, long commands only
// - sense key in byte 2 bits 3..0
// - recovery action reports key 1h
// - illegal command block parameter leaves medium untouched
// - info bytes hold LBA when valid, no mismatch
// - value above 0xFFFFFFF clears the valid flag
// - mismatch puts two's complement residue in info
// - info bytes zero whenever valid is zero
// - byte 7 always 18h
// - control bit 0 selects descriptor, which refuses check condition frames
// - check condition frame is exactly 32 bytes
// - request sense sends min(allocation, 32) bytes
// - bytes 8 to 11 are zero
`timescale 1ns/100ps
module fsf_formatter
  import fsf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata_r,
  input  wire logic        err_load,
  input  wire fsf_err_s    err_in,
  input  wire logic        chk_start,
  input  wire logic        req_start,
  input  wire logic [7:0]  alloc_len,
  input  wire logic        out_ready,
  output logic             out_valid_r,
  output logic [7:0]       out_byte_r,
  output logic             out_last_r,
  output logic             medium_hold_r,
  output logic             desc_fmt_r,
  output logic             irq_r
);

  fsf_state_e  state_r;
  fsf_frame_s  frame_r;
  logic [5:0]  idx_r;
  logic [5:0]  len_r;
  logic [31:0] ctrl_r;
  logic [2:0]  status_r;
  logic [2:0]  mask_r;
  logic [15:0] frames_r;
  logic [7:0]  last_b0_r;
  logic        calc_valid;
  logic        calc_mismatch;
  logic [31:0] calc_info;
  logic [3:0]  key_fix;
  logic [2:0]  st_set;
  logic        start;
  logic        refuse;
  logic [5:0]  req_len;

  // valid flag and information bytes from the raw report
  fsf_info_calc u_info (
    .err      (err_in),
    .valid    (calc_valid),
    .mismatch (calc_mismatch),
    .info     (calc_info)
  );

  // one byte of the fixed frame by index
  function automatic logic [7:0] sense_byte(input logic [5:0] i, input fsf_frame_s f);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      6'd0:  b = {f.valid, f.deferred ? RC_DEF_FIXED : RC_CUR_FIXED};
      6'd2:  b = {2'b00, f.mismatch, 1'b0, f.key};
      6'd3:  b = f.info[31:24];
      6'd4:  b = f.info[23:16];
      6'd5:  b = f.info[15:8];
      6'd6:  b = f.info[7:0];
      6'd7:  b = ADD_SENSE_LEN;
      6'd12: b = f.asc;
      6'd13: b = f.ascq;
      6'd15: b = {f.key_specific_valid, f.key_specific_valid ? f.sks[22:16] : 7'h00};
      6'd16: b = f.key_specific_valid ? f.sks[15:8] : 8'h00;
      6'd17: b = f.key_specific_valid ? f.sks[7:0] : 8'h00;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : sense_byte

  // register address match, used by several processes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  // sense key cleanup: recovery forces 1h, unused codes become aborted
  always_comb begin
    key_fix = err_in.key;
    if (err_in.recovered) begin
      key_fix = SK_RECOVERED;
    end else begin
      case (err_in.key)
        4'h8, 4'ha, 4'hc, 4'hd: key_fix = SK_ABORTED;
        default: key_fix = err_in.key;
      endcase
    end
  end

  // start decode and length choice
  always_comb begin
    start   = 1'b0;
    refuse  = 1'b0;
    req_len = FIXED_LEN;
    if (state_r == FSF_IDLE) begin
      if (chk_start) begin
        refuse = ctrl_r[0];
        start  = ~ctrl_r[0];
        req_len = FIXED_LEN;
      end else if (req_start) begin
        start   = alloc_len != 8'h00;
        req_len = (alloc_len < 8'(FIXED_LEN)) ? alloc_len[5:0] : FIXED_LEN;
      end
    end else if (chk_start || req_start) begin
      refuse = 1'b1;
    end
  end

  // capture of one error report while idle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_r <= '0;
    end else if (err_load && state_r == FSF_IDLE) begin
      frame_r.valid              <= calc_valid;
      frame_r.deferred           <= err_in.deferred;
      frame_r.mismatch           <= calc_mismatch;
      frame_r.key                <= key_fix;
      frame_r.info               <= calc_info;
      frame_r.asc                <= err_in.asc;
      frame_r.ascq               <= err_in.ascq;
      frame_r.key_specific_valid <= err_in.sks_valid;
      frame_r.sks                <= err_in.sks;
    end
  end

  // medium write hold for a bad command block parameter
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      medium_hold_r <= 1'b0;
    end else if (err_load && state_r == FSF_IDLE) begin
      medium_hold_r <= (key_fix == SK_ILLEGAL) & err_in.in_cdb;
    end
  end

  // frame sequencer, bytes leave in ascending order
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r     <= FSF_IDLE;
      idx_r       <= '0;
      len_r       <= '0;
      out_valid_r <= 1'b0;
      out_byte_r  <= 8'h00;
      out_last_r  <= 1'b0;
    end else begin
      case (state_r)
        FSF_IDLE: begin
          if (start) begin
            state_r     <= FSF_SEND;
            len_r       <= req_len;
            idx_r       <= 6'd1;
            out_valid_r <= 1'b1;
            out_byte_r  <= sense_byte(6'd0, frame_r);
            out_last_r  <= req_len == 6'd1;
          end
        end
        FSF_SEND: begin
          if (out_ready) begin
            if (out_last_r) begin
              state_r     <= FSF_IDLE;
              out_valid_r <= 1'b0;
              out_last_r  <= 1'b0;
              out_byte_r  <= 8'h00;
            end else begin
              idx_r      <= idx_r + 6'd1;
              out_byte_r <= sense_byte(idx_r, frame_r);
              out_last_r <= (idx_r + 6'd1) == len_r;
            end
          end
        end
        default: begin
          state_r     <= FSF_IDLE;
          out_valid_r <= 1'b0;
        end
      endcase
    end
  end

  // control register, descriptor select in bit 0
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r     <= CTRL_RST;
      desc_fmt_r <= 1'b0;
    end else begin
      if (reg_wr && hit(reg_addr, REG_CTRL)) begin
        ctrl_r <= {31'h0, reg_wdata[0]};
      end
      desc_fmt_r <= ctrl_r[0];
    end
  end

  // sticky events: frame done, refused start, deferred frame sent
  always_comb begin
    st_set = 3'h0;
    st_set[ST_DONE]     = state_r == FSF_SEND && out_ready && out_last_r;
    st_set[ST_REFUSED]  = refuse;
    st_set[ST_DEFERRED] = st_set[ST_DONE] && frame_r.deferred;
  end

  // status clears by writing one; a new event wins over the clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= 3'h0;
    end else if (reg_wr && hit(reg_addr, REG_STATUS)) begin
      status_r <= (status_r & ~reg_wdata[2:0]) | st_set;
    end else begin
      status_r <= status_r | st_set;
    end
  end

  // mask register and interrupt line
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_r <= MASK_RST;
      irq_r  <= 1'b0;
    end else begin
      if (reg_wr && hit(reg_addr, REG_MASK)) begin
        mask_r <= reg_wdata[2:0];
      end
      irq_r <= |(status_r & mask_r);
    end
  end

  // frame counter and last byte 0 sent
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frames_r  <= 16'h0000;
      last_b0_r <= 8'h00;
    end else begin
      if (st_set[ST_DONE]) begin
        frames_r <= frames_r + 16'h0001;
      end
      if (start) begin
        last_b0_r <= sense_byte(6'd0, frame_r);
      end
    end
  end

  // read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   reg_rdata_r <= ctrl_r;
        REG_STATUS: reg_rdata_r <= {29'h0, status_r};
        REG_MASK:   reg_rdata_r <= {29'h0, mask_r};
        REG_FRAMES: reg_rdata_r <= {16'h0, frames_r};
        REG_LAST:   reg_rdata_r <= {24'h0, last_b0_r};
        default:    reg_rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_r <= 32'h0000_0000;
    end
  end

  // checks
  sequence s_first_byte;
    out_valid_r && idx_r == 6'd1 && $rose(out_valid_r);
  endsequence

  chk_resp_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_first_byte |-> out_byte_r[6:0] == (frame_r.deferred ? RC_DEF_FIXED : RC_CUR_FIXED))
    else $error("byte 0 response code wrong");

  chk_valid_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_first_byte |-> out_byte_r[VALID_BIT] == frame_r.valid)
    else $error("valid bit wrong");

  chk_add_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    out_valid_r && idx_r == 6'd8 && $changed(idx_r) |-> out_byte_r == ADD_SENSE_LEN)
    else $error("additional length not 18h");

  chk_zero_info: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !frame_r.valid |-> frame_r.info == 32'h0000_0000)
    else $error("info not zero while invalid");

  chk_csi_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    out_valid_r && idx_r >= 6'd9 && idx_r <= 6'd12 |-> out_byte_r == 8'h00)
    else $error("command specific bytes not zero");

  chk_mismatch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    err_load && state_r == FSF_IDLE && !err_in.long_cmd |=> !frame_r.mismatch)
    else $error("mismatch flag set for other command");

  chk_full_frame: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_r == FSF_IDLE && chk_start && !ctrl_r[0] |=> len_r == FIXED_LEN)
    else $error("check condition frame not 32 bytes");

  chk_req_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_r == FSF_IDLE && !chk_start && req_start && alloc_len == 8'd5
    |=> len_r == 6'd5 ##0 (out_valid_r && !out_last_r))
    else $error("request length not limited by allocation");

  chk_desc_refuse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_r == FSF_IDLE && chk_start && ctrl_r[0] |=> !out_valid_r ##0 status_r[ST_REFUSED])
    else $error("fixed frame sent while descriptor selected");

  chk_irq_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (status_r & mask_r) != 3'h0 |=> irq_r)
    else $error("interrupt missing");

endmodule : fsf_formatter

// ### design/fsf_pkg.sv
package fsf_pkg;

  // response codes, byte 0 bits 6..0
  localparam logic [6:0]  RC_CUR_FIXED  = 7'h70;
  localparam logic [6:0]  RC_DEF_FIXED  = 7'h71;
  localparam logic [6:0]  RC_CUR_DESC   = 7'h72;
  localparam logic [6:0]  RC_DEF_DESC   = 7'h73;

  // sense keys
  localparam logic [3:0]  SK_NO_SENSE   = 4'h0;
  localparam logic [3:0]  SK_RECOVERED  = 4'h1;
  localparam logic [3:0]  SK_ILLEGAL    = 4'h5;
  localparam logic [3:0]  SK_ABORTED    = 4'hb;

  // frame layout
  localparam logic [5:0]  FIXED_LEN     = 6'h20;       // 32 bytes
  localparam logic [7:0]  ADD_SENSE_LEN = 8'h18;
  localparam logic [63:0] INFO_MAX      = 64'h0fffffff;
  localparam int          VALID_BIT     = 7;
  localparam int          MISMATCH_BIT  = 5;
  localparam int          KSV_BIT       = 7;

  // register offsets and values after reset
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_MASK      = 8'h08;
  localparam logic [7:0]  REG_FRAMES    = 8'h0c;
  localparam logic [7:0]  REG_LAST      = 8'h10;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [2:0]  MASK_RST      = 3'h0;

  // status bit positions
  localparam int          ST_DONE       = 0;
  localparam int          ST_REFUSED    = 1;
  localparam int          ST_DEFERRED   = 2;

  // one error report as handed over by the command logic
  typedef struct packed {
    logic        deferred;     // error of an earlier, already good command
    logic        recovered;    // completed after recovery action
    logic        info_valid;   // info carries a meaningful value
    logic        long_cmd;     // long read or long write
    logic        len_mismatch; // block length differs from the stored one
    logic        in_cdb;       // bad parameter found in the command block
    logic [3:0]  key;
    logic [63:0] lba;
    logic [31:0] residue;      // signed, two's complement
    logic [7:0]  asc;
    logic [7:0]  ascq;
    logic        sks_valid;
    logic [22:0] sks;
  } fsf_err_s;

  // captured frame fields
  typedef struct packed {
    logic        valid;
    logic        deferred;
    logic        mismatch;
    logic [3:0]  key;
    logic [31:0] info;
    logic [7:0]  asc;
    logic [7:0]  ascq;
    logic        key_specific_valid;
    logic [22:0] sks;
  } fsf_frame_s;

  typedef enum logic [1:0] {
    FSF_IDLE = 2'b01,
    FSF_SEND = 2'b10
  } fsf_state_e;

endpackage : fsf_pkg

// ### design/fsf_info_calc.sv
`timescale 1ns/100ps
module fsf_info_calc
  import fsf_pkg::*;
(
  input  wire fsf_err_s    err,
  output logic             valid,
  output logic             mismatch,
  output logic [31:0]      info
);

  // valid flag, mismatch flag and information bytes
  always_comb begin
    mismatch = err.long_cmd & err.len_mismatch;
    if (mismatch) begin
      valid = err.info_valid;
      info  = err.residue;
    end else begin
      valid = err.info_valid & (err.lba <= INFO_MAX);
      info  = err.lba[31:0];
    end
    if (!valid) begin
      info = 32'h0000_0000;
    end
  end

endmodule : fsf_info_calc

// ### tb/fsf_initiator.sv
`timescale 1ns/100ps
module fsf_initiator (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       slow,
  input  wire logic       out_valid_r,
  input  wire logic [7:0] out_byte_r,
  input  wire logic       out_last_r,
  output logic            out_ready,
  output logic [7:0]      rx_buf [32],
  output logic [7:0]      rx_cnt,
  output logic            rx_done
);
  logic [7:0] idx_r;
  logic [2:0] stall_r;

  // consumer: stalls in slow mode, stores bytes in arrival order
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_ready <= 1'b0;
      idx_r     <= 8'h00;
      stall_r   <= 3'h0;
      rx_cnt    <= 8'h00;
      rx_done   <= 1'b0;
    end else begin
      stall_r   <= stall_r + 3'h1;
      out_ready <= !slow || stall_r[1];
      rx_done   <= 1'b0;
      if (out_valid_r && out_ready) begin
        rx_buf[idx_r[4:0]] <= out_byte_r;
        idx_r              <= out_last_r ? 8'h00 : idx_r + 8'h01;
        if (out_last_r) begin
          rx_cnt  <= idx_r + 8'h01; // count of bytes taken in this frame
          rx_done <= 1'b1;
        end
      end
    end
  end
endmodule : fsf_initiator

// ### tb/fsf_formatter_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module fsf_formatter_tb;
  import fsf_pkg::*;
  logic         ref_clk, sys_rst, reg_wr, reg_rd, err_load, chk_start, req_start;
  logic         out_ready, slow, out_valid_r, out_last_r, medium_hold_r;
  logic         desc_fmt_r, irq_r, rx_done;
  logic [7:0]   reg_addr, alloc_len, out_byte_r, rx_cnt, last0;
  logic [31:0]  reg_wdata, reg_rdata_r, d;
  logic [7:0]   rx_buf [32];
  logic [7:0]   ef [32];
  logic [159:0] r;
  logic [2:0]   st, mask;
  fsf_err_s     err_in, cur;
  int           error_cnt, checks, nfr, k;
  integer       seed;
  logic [7:0]   alist [8] = '{8'd0, 8'd1, 8'd5, 8'd17, 8'd31, 8'd32, 8'd33, 8'd255};

  fsf_formatter uut (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r, .err_load, .err_in, .chk_start, .req_start, .alloc_len, .out_ready,
    .out_valid_r, .out_byte_r, .out_last_r, .medium_hold_r, .desc_fmt_r, .irq_r);
  fsf_initiator partner (.ref_clk, .sys_rst, .slow, .out_valid_r, .out_byte_r,
    .out_last_r, .out_ready, .rx_buf, .rx_cnt, .rx_done);

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task end_sim;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata_r;
  endtask : rd

  // reference frame for one error report
  task automatic load(input fsf_err_s x);
    logic        v, m;
    logic [3:0]  kk;
    logic [31:0] inf;
    m  = x.long_cmd & x.len_mismatch;
    v  = m ? x.info_valid : (x.info_valid && x.lba <= 64'h0fffffff);
    kk = x.recovered ? 4'h1 : x.key;
    if (kk inside {4'h8, 4'ha, 4'hc, 4'hd}) kk = 4'hb;
    inf = !v ? 32'h0 : (m ? x.residue : x.lba[31:0]);
    foreach (ef[i]) ef[i] = 8'h00;
    ef[0] = {v, x.deferred ? 7'h71 : 7'h70};
    ef[2] = {2'b00, m, 1'b0, kk};
    {ef[3], ef[4], ef[5], ef[6]} = inf;
    ef[7]  = 8'h18;
    ef[12] = x.asc;
    ef[13] = x.ascq;
    if (x.sks_valid) {ef[15], ef[16], ef[17]} = {1'b1, x.sks};
    @(posedge ref_clk);
    err_in   <= x;
    err_load <= 1'b1;
    @(posedge ref_clk);
    err_load <= 1'b0;
    #1;
    `CHK(medium_hold_r, kk == 4'h5 && x.in_cdb)
  endtask : load

  task start(input logic c, input logic [7:0] a);
    @(posedge ref_clk);
    chk_start <= c;
    req_start <= !c;
    alloc_len <= a;
    @(posedge ref_clk);
    chk_start <= 1'b0;
    req_start <= 1'b0;
  endtask : start

  // wait for the frame, compare bytes, status and interrupt
  task fin(input int n);
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (rx_done !== 1'b1 && k < 400);
    if (k >= 400) begin
      error_cnt++;
      $display("unexpected at %0t: frame never ended", $time);
      end_sim;
    end
    `CHK(rx_cnt, n[7:0])
    for (int i = 0; i < n; i++) `CHK(rx_buf[i], ef[i])
    nfr++;
    last0 = ef[0];
    st    = st | {cur.deferred, 1'b0, 1'b1};
    cyc(2);
    `CHK(irq_r, |(st & mask))
    rd(REG_STATUS);
    `CHK(d, {29'h0, st})
    wr(REG_STATUS, 32'h7);
    st = 3'h0;
    cyc(2);
    `CHK(irq_r, 1'b0)
  endtask : fin

  task frame(input logic c, input logic [7:0] a);
    int n;
    n = c ? 32 : (a > 8'd32 ? 32 : int'(a));
    start(c, a);
    if (n == 0) begin
      cyc(4);
      `CHK(out_valid_r, 1'b0)
    end else fin(n);
  endtask : frame

  // watchdog
  initial begin
    #2400000;
    error_cnt++;
    $display("unexpected at %0t: watchdog", $time);
    end_sim;
  end

  // main sequence
  initial begin
    {reg_wr, reg_rd, err_load, chk_start, req_start, slow} = '0;
    {reg_addr, alloc_len, reg_wdata} = '0;
    err_in = '0;
    {st, mask, error_cnt, checks, nfr} = '0;
    seed    = 32'he385e277;
    sys_rst = 1'b1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 `CHK({out_valid_r, irq_r, medium_hold_r}, 3'h0)
    rd(REG_CTRL);
    `CHK(d, 32'h0)
    rd(REG_MASK);
    `CHK(d, 32'h0)
    wr(8'h14, 32'hffffffff);
    rd(8'h14);
    `CHK(d, 32'h0)
    // every sense key, lba at both sides of the limit, random masks
    for (int i = 0; i < 24; i++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      cur           = r[145:0];
      cur.key       = (i < 16) ? i[3:0] : r[151:148];
      cur.recovered = (i >= 16) && r[150];
      cur.lba = (i % 3 == 0) ? 64'h0fffffff : (i % 3 == 1) ? 64'h10000000 : {36'h0, r[27:0]};
      mask = r[154:152];
      slow <= i[0];
      wr(REG_MASK, {29'h0, mask});
      rd(REG_MASK);
      `CHK(d, {29'h0, mask})
      load(cur);
      frame(1'b1, 8'h00);
    end
    // allocation lengths around the frame size
    foreach (alist[j]) begin
      load(cur);
      frame(1'b0, alist[j]);
    end
    // descriptor select refuses check-condition frames only
    wr(REG_CTRL, 32'h1);
    cyc(1);
    `CHK(desc_fmt_r, 1'b1)
    rd(REG_CTRL);
    `CHK(d, 32'h1)
    start(1'b1, 8'h00);
    cyc(4);
    `CHK(out_valid_r, 1'b0)
    st = 3'h2;
    frame(1'b0, 8'd32);
    wr(REG_CTRL, 32'h0);
    // start while a slow frame is in flight is refused
    slow <= 1'b1;
    load(cur);
    start(1'b1, 8'h00);
    cyc(3);
    start(1'b0, 8'd5);
    st = 3'h2;
    fin(32);
    rd(REG_FRAMES);
    `CHK(d, {16'h0, nfr[15:0]})
    rd(REG_LAST);
    `CHK(d, {24'h0, last0})
    end_sim;
  end
endmodule : fsf_formatter_tb
